// [hfc_pkg.sv]
// Shared constants and types for the hybrid flow pipeline classifier.
package hfc_pkg;
	localparam int NUM_PORTS   = 57;
	localparam int NUM_ENT     = 8;
	localparam int BLK_ENT     = 4;
	localparam int PKT_CNT_W   = 36;
	localparam int BYTE_CNT_W  = 42;
	localparam int LEN_W       = 14;
	// Register byte offsets.
	localparam logic [7:0] A_PORT_LO   = 8'h00;
	localparam logic [7:0] A_PORT_HI   = 8'h04;
	localparam logic [7:0] A_VLAN_IDX  = 8'h08;
	localparam logic [7:0] A_VLAN_DAT  = 8'h0c;
	localparam logic [7:0] A_ENT_SEL   = 8'h10;
	localparam logic [7:0] A_ENT_OPS   = 8'h14;
	localparam logic [7:0] A_HIT       = 8'h18;
	localparam logic [7:0] A_PKT_LO    = 8'h1c;
	localparam logic [7:0] A_PKT_HI    = 8'h20;
	localparam logic [7:0] A_BYTE_LO   = 8'h24;
	localparam logic [7:0] A_BYTE_HI   = 8'h28;
	localparam logic [7:0] A_STATUS    = 8'h2c;
	// Field positions.
	localparam int EN_BIT      = 0;
	localparam int COMB_BIT    = 1;
	localparam int OP_INV      = 0;
	localparam int OP_WITHIN   = 1;
	localparam int OP_ACROSS   = 2;
	// Reset values.
	localparam logic [NUM_PORTS-1:0] PORT_EN_RST = '0;
	localparam logic [1:0]  VLAN_RST    = 2'h0;
	localparam logic [2:0]  OPS_RST     = 3'h0;
	// Action set output types with special meaning.
	localparam logic [3:0]  OUT_NONE    = 4'h0;
	localparam logic [3:0]  OUT_LB_NORM = 4'h8;
	// Range-check bits carrying packet length and L3 length results.
	localparam logic [15:0] RNG_LEN_BITS = 16'hf000;
	// Two-bit TTL classes and destination MAC classes.
	localparam logic [1:0]  TTL_ZERO = 2'h0;
	localparam logic [1:0]  TTL_ONE  = 2'h1;
	localparam logic [1:0]  TTL_MID  = 2'h2;
	localparam logic [1:0]  TTL_MAX  = 2'h3;
	localparam logic [1:0]  MAC_UC   = 2'h0;
	localparam logic [1:0]  MAC_BC   = 2'h1;
	localparam logic [1:0]  MAC_MC   = 2'h3;
	typedef enum logic [1:0] {DST_UC, DST_BC, DST_MC} mac_kind_t;
endpackage

// [entry_stats_if.sv]
// Carrier between the classifier core and one full-match entry's statistics.
`timescale 1ns/1ps
interface entry_stats_if;
	import hfc_pkg::*;
	logic                  hit_upd;
	logic [LEN_W-1:0]      len;
	logic                  clr_hit;
	logic                  hit;
	logic [PKT_CNT_W-1:0]  pkt_cnt;
	logic [BYTE_CNT_W-1:0] byte_cnt;
	modport core (output hit_upd, len, clr_hit, input hit, pkt_cnt, byte_cnt);
	modport ent  (input hit_upd, len, clr_hit, output hit, pkt_cnt, byte_cnt);
endinterface

// [flow_entry_stats.sv]
// Packet counter, byte counter and hit flag of one full-match entry.
`timescale 1ns/1ps
module flow_entry_stats
	import hfc_pkg::*;
(
	input  wire logic   i_core_clk,
	input  wire logic   i_nrst,
	input  wire logic   i_ce,
	entry_stats_if.ent  st
);
	// Counters wrap; software reads them as free-running totals.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st.pkt_cnt  <= '0;
			st.byte_cnt <= '0;
		end else if (i_ce && st.hit_upd) begin
			st.pkt_cnt  <= st.pkt_cnt + 1'b1;
			st.byte_cnt <= st.byte_cnt + BYTE_CNT_W'(st.len);
		end
	end

	// A match in the clearing cycle keeps the flag set.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st.hit <= 1'b0;
		end else if (i_ce) begin
			if (st.hit_upd) begin
				st.hit <= 1'b1;
			end else if (st.clr_hit) begin
				st.hit <= 1'b0;
			end
		end
	end
endmodule

// [flow_match_op.sv]
// Match operation stage of one full-match entry: invert and aggregation.
`timescale 1ns/1ps
module flow_match_op (
	input  wire logic i_raw,
	input  wire logic i_prev_in_blk,
	input  wire logic i_prev_blk,
	input  wire logic i_inv,
	input  wire logic i_within,
	input  wire logic i_across,
	output logic      o_match
);
	logic eff;

	// Aggregation ANDs this entry with its neighbour in the block or across blocks.
	always_comb begin
		eff     = i_raw ^ i_inv;
		o_match = eff & (i_within ? i_prev_in_blk : 1'b1) & (i_across ? i_prev_blk : 1'b1);
	end
endmodule

// [hybrid_flow_classifier.sv]
// Hybrid pipeline classifier with key-word builder and full-match entry statistics.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Egress only after action set gives output
// - Per-port enable qualifies for flow pipeline
// - Per-VLAN enable qualifies for flow pipeline
// - Outer tag VLAN, else port VLAN
// - Combine bit: AND when set, else OR
// - Flow packet loops to either pipeline
// - Normal packet loops to normal only
// - One pipeline per packet at a time
// - 36-bit packet and 42-bit byte counters
// - Winning entry match sets its hit flag
// - Invert, within-block, across-block match operations
// - Source mask key words with loopback flag
// - Egress key carries destination port mask
// - Two-bit TTL or hop-limit class
// - Packet class word: port, MAC class
// - Source logical port: trunk or device/port
// - Dest logical port: output type, data
// - Metadata word: loopback count, metadata
// - Tag words: priority, DEI, VLAN ID
// - Tunnel word: MPLS label presence bits
// - Transport flags word layout
// - Range mask; egress drops length results
module hybrid_flow_classifier
	import hfc_pkg::*;
(
	input  wire logic                  i_core_clk,
	input  wire logic                  i_nrst,
	input  wire logic                  i_ce,

	// Register port.
	input  wire logic [7:0]            i_reg_addr,
	input  wire logic [31:0]           i_reg_wdata,
	input  wire logic                  i_reg_wr,
	input  wire logic                  i_reg_rd,
	output logic [31:0]                o_reg_rdata,

	// Parsed packet from the parser.
	input  wire logic                  i_pkt_valid,
	input  wire logic [5:0]            i_src_port,
	input  wire logic                  i_tagged,
	input  wire logic [15:0]           i_outer_tag,
	input  wire logic [15:0]           i_inner_tag,
	input  wire logic [11:0]           i_port_vid,
	input  wire logic [7:0]            i_ttl,
	input  wire logic                  i_dmac_bcast,
	input  wire logic                  i_dmac_mcast,
	input  wire logic                  i_is_trunk,
	input  wire logic [6:0]            i_trunk_id,
	input  wire logic [3:0]            i_dev_id,
	input  wire logic [1:0]            i_mpls_labels,
	input  wire logic [3:0]            i_flow_label_hi,
	input  wire logic                  i_tcp_seq_nz,
	input  wire logic [1:0]            i_tcp_ecn,
	input  wire logic [5:0]            i_tcp_flags,
	input  wire logic [15:0]           i_range_hits,
	input  wire logic [NUM_PORTS-1:0]  i_dst_port_mask,
	input  wire logic [3:0]            i_lb_count,
	input  wire logic [11:0]           i_metadata,

	// Loopback request after a pipeline pass.
	input  wire logic                  i_lb_valid,
	input  wire logic                  i_lb_from_flow,
	input  wire logic                  i_lb_to_flow,

	// Accumulated action set.
	input  wire logic                  i_as_valid,
	input  wire logic [3:0]            i_as_out_type,
	input  wire logic [11:0]           i_as_out_data,

	// Rule engine raw matches and packet length.
	input  wire logic                  i_match_valid,
	input  wire logic [NUM_ENT-1:0]    i_raw_match,
	input  wire logic [LEN_W-1:0]      i_match_len,

	// Steering result.
	output logic                       o_to_flow,
	output logic                       o_to_normal,
	output logic                       o_egress_go,
	output logic                       o_lb_normal,
	output logic [NUM_ENT-1:0]         o_entry_match,

	// Key words.
	output logic [63:0]                o_src_mask_key,
	output logic [63:0]                o_dst_mask_key,
	output logic [15:0]                o_packet_class_word,
	output logic [15:0]                o_source_logical_port_word,
	output logic [15:0]                o_dest_logical_port_word,
	output logic [15:0]                o_metadata_word,
	output logic [15:0]                o_outer_tag_word,
	output logic [15:0]                o_inner_tag_word,
	output logic [15:0]                o_tunnel_type_word,
	output logic [15:0]                o_transport_flags_word,
	output logic [1:0]                 o_ttl_class,
	output logic [15:0]                o_range_result_mask,
	output logic [15:0]                o_range_result_mask_eg
);
	import hfc_pkg::*;

	// Configuration and last steering status in flip-flops; software owns all but last_flow_r.
	logic [NUM_PORTS-1:0] port_flow_steer_enable_r;
	logic [1:0]           vlan_tbl_r [4096];
	logic [11:0]          vlan_idx_r;
	logic [2:0]           ent_sel_r;
	logic [2:0]           ent_ops_r [NUM_ENT];
	logic                 last_flow_r;
	// Per-packet decode nets; none of these hold state.
	logic [NUM_ENT-1:0]   hits;
	logic [NUM_ENT-1:0]   res;
	logic [NUM_ENT-1:0]   win;
	logic [11:0]          vid_sel;
	logic                 port_ok;
	logic                 vlan_ok;
	logic                 comb_and;
	logic                 flow_nxt;
	logic                 hit_clr_wr;
	mac_kind_t            mac_kind;
	logic [1:0]           ttl_nxt;
	logic [31:0]          rdata_nxt;
	logic [PKT_CNT_W-1:0]  sel_pkt;
	logic [BYTE_CNT_W-1:0] sel_byte;
	logic [PKT_CNT_W-1:0]  pkt_arr  [NUM_ENT];
	logic [BYTE_CNT_W-1:0] byte_arr [NUM_ENT];

	// One statistics carrier per full-match entry.
	entry_stats_if st [NUM_ENT] ();

	// Register writes; the VLAN data word lands at the entry picked by the index.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			port_flow_steer_enable_r <= PORT_EN_RST;
			vlan_idx_r <= '0;
			ent_sel_r  <= '0;
		end else if (i_ce && i_reg_wr) begin
			unique case (i_reg_addr)
				A_PORT_LO:  port_flow_steer_enable_r[31:0] <= i_reg_wdata;
				A_PORT_HI:  port_flow_steer_enable_r[NUM_PORTS-1:32] <= i_reg_wdata[24:0];
				A_VLAN_IDX: vlan_idx_r <= i_reg_wdata[11:0];
				A_ENT_SEL:  ent_sel_r  <= i_reg_wdata[2:0];
				default: ;
			endcase
		end
	end

	// VLAN table in flip-flops: enable and combine bit per VLAN.
	// Full depth costs area but gives a decision with no lookup latency.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int v = 0; v < 4096; v++) begin
				vlan_tbl_r[v] <= VLAN_RST;
			end
		end else if (i_ce && i_reg_wr && i_reg_addr == A_VLAN_DAT) begin
			vlan_tbl_r[vlan_idx_r] <= i_reg_wdata[1:0];
		end
	end

	// Per-entry match operation settings, written through the entry selector.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int e = 0; e < NUM_ENT; e++) begin
				ent_ops_r[e] <= OPS_RST;
			end
		end else if (i_ce && i_reg_wr && i_reg_addr == A_ENT_OPS) begin
			ent_ops_r[ent_sel_r] <= i_reg_wdata[2:0];
		end
	end

	// Write-one-to-clear; a match in the same cycle keeps its flag.
	assign hit_clr_wr = i_reg_wr && (i_reg_addr == A_HIT);

	// Read mux; unmapped offsets read zero.
	always_comb begin
		sel_pkt   = pkt_arr[ent_sel_r];
		sel_byte  = byte_arr[ent_sel_r];
		rdata_nxt = 32'h0;
		unique case (i_reg_addr)
			A_PORT_LO:  rdata_nxt = port_flow_steer_enable_r[31:0];
			A_PORT_HI:  rdata_nxt = {7'h0, port_flow_steer_enable_r[NUM_PORTS-1:32]};
			A_VLAN_IDX: rdata_nxt = {20'h0, vlan_idx_r};
			A_VLAN_DAT: rdata_nxt = {30'h0, vlan_tbl_r[vlan_idx_r]};
			A_ENT_SEL:  rdata_nxt = {29'h0, ent_sel_r};
			A_ENT_OPS:  rdata_nxt = {29'h0, ent_ops_r[ent_sel_r]};
			A_HIT:      rdata_nxt = {24'h0, hits};
			A_PKT_LO:   rdata_nxt = sel_pkt[31:0];
			A_PKT_HI:   rdata_nxt = {28'h0, sel_pkt[PKT_CNT_W-1:32]};
			A_BYTE_LO:  rdata_nxt = sel_byte[31:0];
			A_BYTE_HI:  rdata_nxt = {22'h0, sel_byte[BYTE_CNT_W-1:32]};
			A_STATUS:   rdata_nxt = {31'h0, last_flow_r};
			default:    rdata_nxt = 32'h0;
		endcase
	end

	// Read data stands for the one cycle after the strobe.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_reg_rdata <= '0;
		end else if (i_ce) begin
			o_reg_rdata <= i_reg_rd ? rdata_nxt : 32'h0;
		end
	end

	// Steering decision; a loopback request overrides classification.
	always_comb begin
		vid_sel  = i_tagged ? i_outer_tag[11:0] : i_port_vid;
		port_ok  = port_flow_steer_enable_r[i_src_port];
		vlan_ok  = vlan_tbl_r[vid_sel][EN_BIT];
		comb_and = vlan_tbl_r[vid_sel][COMB_BIT];
		flow_nxt = comb_and ? (port_ok & vlan_ok) : (port_ok | vlan_ok);
		if (i_lb_valid) begin
			// A normal-pipeline packet can never re-enter the flow pipeline.
			flow_nxt = i_lb_from_flow & i_lb_to_flow;
		end
	end

	// Exactly one of the two pipeline strobes fires per packet.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_to_flow   <= 1'b0;
			o_to_normal <= 1'b0;
			last_flow_r <= 1'b0;
		end else if (i_ce) begin
			o_to_flow   <= (i_pkt_valid | i_lb_valid) & flow_nxt;
			o_to_normal <= (i_pkt_valid | i_lb_valid) & ~flow_nxt;
			if (i_pkt_valid | i_lb_valid) begin
				last_flow_r <= flow_nxt;
			end
		end
	end

	// Egress release waits for a resolved output; type 8 returns to normal.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_egress_go <= 1'b0;
			o_lb_normal <= 1'b0;
		end else if (i_ce) begin
			o_egress_go <= i_as_valid && i_as_out_type != OUT_NONE
				&& i_as_out_type != OUT_LB_NORM;
			o_lb_normal <= i_as_valid && i_as_out_type == OUT_LB_NORM;
		end
	end

	// Key-field encoders.
	always_comb begin
		if (i_ttl == 8'h00) begin
			ttl_nxt = TTL_ZERO;
		end else if (i_ttl == 8'h01) begin
			ttl_nxt = TTL_ONE;
		end else if (i_ttl == 8'hff) begin
			ttl_nxt = TTL_MAX;
		end else begin
			ttl_nxt = TTL_MID;
		end
		mac_kind = i_dmac_bcast ? DST_BC : (i_dmac_mcast ? DST_MC : DST_UC);
	end

	// Key words are registered with the packet so they line up with the strobes.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_src_mask_key             <= '0;
			o_dst_mask_key             <= '0;
			o_packet_class_word        <= '0;
			o_source_logical_port_word <= '0;
			o_dest_logical_port_word   <= '0;
			o_metadata_word            <= '0;
			o_outer_tag_word           <= '0;
			o_inner_tag_word           <= '0;
			o_tunnel_type_word         <= '0;
			o_transport_flags_word     <= '0;
			o_ttl_class                <= '0;
			o_range_result_mask        <= '0;
			o_range_result_mask_eg     <= '0;
		end else if (i_ce && (i_pkt_valid | i_lb_valid)) begin
			o_src_mask_key <= {i_lb_valid, 6'h0, 57'(64'h1 << i_src_port)};
			o_dst_mask_key <= {7'h0, i_dst_port_mask};
			unique case (mac_kind)
				DST_BC:  o_packet_class_word <= {i_src_port, MAC_BC, 8'h0};
				DST_MC:  o_packet_class_word <= {i_src_port, MAC_MC, 8'h0};
				DST_UC:  o_packet_class_word <= {i_src_port, MAC_UC, 8'h0};
				default: o_packet_class_word <= {i_src_port, MAC_UC, 8'h0};
			endcase
			o_source_logical_port_word <= i_is_trunk ? {5'h0, 1'b1, 3'h0, i_trunk_id}
				: {5'h0, 1'b0, i_dev_id, i_src_port};
			o_dest_logical_port_word <= {i_as_out_type, i_as_out_data};
			o_metadata_word          <= {i_lb_count, i_metadata};
			o_outer_tag_word         <= i_outer_tag;
			o_inner_tag_word         <= i_inner_tag;
			o_tunnel_type_word       <= {i_mpls_labels, 14'h0};
			o_transport_flags_word   <= {3'h0, i_flow_label_hi, i_tcp_seq_nz,
				i_tcp_ecn, i_tcp_flags};
			o_ttl_class              <= ttl_nxt;
			o_range_result_mask      <= i_range_hits;
			o_range_result_mask_eg   <= i_range_hits & ~RNG_LEN_BITS;
		end
	end

	// Match operations chain through neighbours; the first entry of a block
	// and the first block see a true neighbour, so aggregation there is a no-op.
	for (genvar e = 0; e < NUM_ENT; e++) begin : g_ent
		logic pin;
		logic pbk;
		assign pin = (e % BLK_ENT == 0) ? 1'b1 : res[(e + NUM_ENT - 1) % NUM_ENT];
		assign pbk = (e < BLK_ENT) ? 1'b1 : res[(e + NUM_ENT - BLK_ENT) % NUM_ENT];
		flow_match_op u_op (
			.i_raw         (i_raw_match[e]),
			.i_prev_in_blk (pin),
			.i_prev_blk    (pbk),
			.i_inv         (ent_ops_r[e][OP_INV]),
			.i_within      (ent_ops_r[e][OP_WITHIN]),
			.i_across      (ent_ops_r[e][OP_ACROSS]),
			.o_match       (res[e])
		);
		// Only the winning entry counts and flags; that keeps totals per packet.
		assign st[e].hit_upd = i_match_valid & win[e];
		assign st[e].len     = i_match_len;
		assign st[e].clr_hit = hit_clr_wr & i_reg_wdata[e];
		assign hits[e]       = st[e].hit;
		assign pkt_arr[e]    = st[e].pkt_cnt;
		assign byte_arr[e]   = st[e].byte_cnt;
		flow_entry_stats u_st (
			.i_core_clk (i_core_clk),
			.i_nrst     (i_nrst),
			.i_ce       (i_ce),
			.st         (st[e])
		);
	end

	// Lowest index is the highest priority.
	assign win = res & (~res + 1'b1);

	// All results are shown, not only the winner, so overlaps stay visible.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_entry_match <= '0;
		end else if (i_ce) begin
			o_entry_match <= i_match_valid ? res : '0;
		end
	end
endmodule

// [pkt_parser_model.sv]
// Packet parser model that hands parsed packets to the classifier.
`timescale 1ns/1ps
module pkt_parser_model (
	input  wire logic   i_core_clk,
	output logic        o_pkt_valid,
	output logic [5:0]  o_src_port,
	output logic        o_tagged,
	output logic [15:0] o_outer_tag,
	output logic [15:0] o_inner_tag,
	output logic [11:0] o_port_vid,
	output logic [7:0]  o_ttl
);
	// Quiet parser outputs from time zero.
	initial begin
		o_pkt_valid = 1'b0;
		{o_src_port, o_tagged, o_outer_tag, o_inner_tag, o_port_vid, o_ttl} = '0;
	end

	// One packet per call; after the pulse the fields are inverted, so a
	// classifier that samples late sees garbage instead of a lucky match.
	task automatic send(input logic [5:0] p, input logic t, input logic [11:0] v,
		input logic [7:0] l);
		@(posedge i_core_clk);
		o_pkt_valid <= 1'b1;
		o_src_port  <= p;
		o_tagged    <= t;
		o_outer_tag <= {3'h5, 1'b1, v};
		o_inner_tag <= {3'h2, 1'b0, ~v};
		o_port_vid  <= 12'h001;
		o_ttl       <= l;
		@(posedge i_core_clk);
		o_pkt_valid <= 1'b0;
		o_src_port  <= ~p;
		o_tagged    <= ~t;
		o_outer_tag <= ~{3'h5, 1'b1, v};
		o_inner_tag <= ~{3'h2, 1'b0, ~v};
		o_port_vid  <= 12'hffe;
		o_ttl       <= ~l;
	endtask
endmodule

// [hybrid_flow_classifier_chk.sv]
// Port-level assertions for the hybrid flow pipeline classifier.
`timescale 1ns/1ps
module classifier_chk
	import hfc_pkg::*;
(
	input  wire logic               i_core_clk,
	input  wire logic               i_nrst,
	input  wire logic               i_ce,
	input  wire logic               i_reg_rd,
	input  wire logic               i_pkt_valid,
	input  wire logic [5:0]         i_src_port,
	input  wire logic [7:0]         i_ttl,
	input  wire logic               i_lb_valid,
	input  wire logic               i_lb_from_flow,
	input  wire logic               i_lb_to_flow,
	input  wire logic               i_as_valid,
	input  wire logic [3:0]         i_as_out_type,
	input  wire logic               i_match_valid,
	input  wire logic [31:0]        o_reg_rdata,
	input  wire logic               o_to_flow,
	input  wire logic               o_to_normal,
	input  wire logic               o_egress_go,
	input  wire logic               o_lb_normal,
	input  wire logic [NUM_ENT-1:0] o_entry_match,
	input  wire logic [63:0]        o_src_mask_key,
	input  wire logic [1:0]         o_ttl_class
);
	// All checks live in the core clock domain.
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	// Steering answers exactly once and never into both pipelines.
	a_one_pipe_only: assert property (!(o_to_flow && o_to_normal))
		else $error("both pipelines");
	a_steer_answer: assert property ((i_ce && (i_pkt_valid || i_lb_valid)) |=>
		(o_to_flow ^ o_to_normal)) else $error("no single steering answer");
	a_lb_normal_only: assert property ((i_ce && i_lb_valid && !i_lb_from_flow) |=>
		(o_to_normal && !o_to_flow)) else $error("normal loopback reached flow");
	a_lb_flow_again: assert property ((i_ce && i_lb_valid && i_lb_from_flow && i_lb_to_flow)
		|=> o_to_flow) else $error("flow loopback refused");
	// Egress only follows an action set that names an output.
	a_egress_cause: assert property (o_egress_go |-> $past(i_as_valid) &&
		$past(i_as_out_type) != OUT_NONE && $past(i_as_out_type) != OUT_LB_NORM)
		else $error("egress without output");
	a_lb_action: assert property ((i_ce && i_as_valid && i_as_out_type == OUT_LB_NORM) |=>
		(o_lb_normal && !o_egress_go)) else $error("normal loopback action lost");
	// Key word checks that tie outputs to the sampled packet.
	a_ttl_max: assert property ((i_ce && i_pkt_valid && !i_lb_valid && i_ttl == 8'hff) |=>
		o_ttl_class == TTL_MAX) else $error("ttl 255 class wrong");
	a_ttl_zero: assert property ((i_ce && i_pkt_valid && !i_lb_valid && i_ttl == 8'h00) |=>
		o_ttl_class == TTL_ZERO) else $error("ttl 0 class wrong");
	a_src_onehot: assert property ((i_ce && i_pkt_valid && !i_lb_valid) |=>
		o_src_mask_key == (64'h1 << $past(i_src_port))) else $error("source mask wrong");
	// Idle outputs return to zero.
	a_rdata_idle: assert property ((i_ce && !i_reg_rd) |=> o_reg_rdata == 32'h0)
		else $error("read data without read");
	a_entry_idle: assert property ((i_ce && !i_match_valid) |=> o_entry_match == '0)
		else $error("match without request");
endmodule

bind hybrid_flow_classifier classifier_chk i_classifier_chk (.*);

// [tb_top.sv]
// Self-checking bench for the hybrid flow pipeline classifier.
`timescale 1ns/1ps
module tb_top;
	import hfc_pkg::*;
	typedef struct {int p, t, v, l, f, c;} row_t;
	localparam logic [117:0] FXB = 118'h2d9e3c5a71b4f086c21e57a93d;
	logic         clk = 0, nrst = 0, ce = 1, wr = 0, rd = 0, lbv = 0, lbf = 0, lbt = 0;
	logic         asv = 0, mv = 0, pv, tg, to_f, to_n, eg, lbn;
	logic [3:0]   ast = 0;
	logic [5:0]   sp;
	logic [7:0]   addr = 0, raw = 0, ttl, em;
	logic [11:0]  asd = 0, pvid;
	logic [13:0]  mlen = 0;
	logic [15:0]  ot, it, w_cls, w_slp, w_dlp, w_md, w_ot, w_it, w_tt, w_tr, rm, rme;
	logic [31:0]  wd = 0, rdata;
	logic [63:0]  smk, dmk;
	logic [117:0] fx = FXB;
	logic [1:0]   ttlc;
	logic [1:0]   cls;
	int           miscompares = 0, tests_run = 0;
	row_t rows [8] = '{'{3,0,5,0,1,0}, '{4,0,5,1,0,1}, '{4,1,5,2,1,2}, '{4,1,7,254,0,2},
		'{3,1,7,255,1,3}, '{3,1,9,128,0,2}, '{40,0,9,64,1,2}, '{41,1,1,255,0,3}};
	logic [15:0] mt [4] = '{16'h0206, 16'h080c, 16'h1400, 16'h1115};

	// Core clock at 250 MHz.
	always #2 clk = ~clk;

	pkt_parser_model i_pkt_parser_model (.i_core_clk(clk), .o_pkt_valid(pv), .o_src_port(sp),
		.o_tagged(tg), .o_outer_tag(ot), .o_inner_tag(it), .o_port_vid(pvid), .o_ttl(ttl));

	hybrid_flow_classifier i_hybrid_flow_classifier (.i_core_clk(clk), .i_nrst(nrst), .i_ce(ce),
		.i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.i_pkt_valid(pv), .i_src_port(sp), .i_tagged(tg), .i_outer_tag(ot), .i_inner_tag(it),
		.i_port_vid(pvid), .i_ttl(ttl), .i_dmac_bcast(fx[0]), .i_dmac_mcast(fx[1]),
		.i_is_trunk(fx[2]), .i_trunk_id(fx[9:3]), .i_dev_id(fx[13:10]), .i_mpls_labels(fx[15:14]),
		.i_tcp_flags(fx[21:16]), .i_tcp_ecn(fx[23:22]), .i_tcp_seq_nz(fx[24]),
		.i_flow_label_hi(fx[28:25]), .i_range_hits(fx[44:29]), .i_lb_count(fx[48:45]),
		.i_metadata(fx[60:49]), .i_dst_port_mask(fx[117:61]), .i_lb_valid(lbv),
		.i_lb_from_flow(lbf), .i_lb_to_flow(lbt), .i_as_valid(asv), .i_as_out_type(ast),
		.i_as_out_data(asd), .i_match_valid(mv), .i_raw_match(raw), .i_match_len(mlen),
		.o_to_flow(to_f), .o_to_normal(to_n), .o_egress_go(eg), .o_lb_normal(lbn),
		.o_entry_match(em), .o_src_mask_key(smk), .o_dst_mask_key(dmk),
		.o_packet_class_word(w_cls), .o_source_logical_port_word(w_slp),
		.o_dest_logical_port_word(w_dlp), .o_metadata_word(w_md), .o_outer_tag_word(w_ot),
		.o_inner_tag_word(w_it), .o_tunnel_type_word(w_tt), .o_transport_flags_word(w_tr),
		.o_ttl_class(ttlc), .o_range_result_mask(rm), .o_range_result_mask_eg(rme));

	// Compare one value; every mismatch is counted and reported at once.
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (e !== g) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic fin(input string n);
		$display("test %s done", n);
	endtask

	// Register writes and reads are single-cycle strobes; read data is checked
	// in the one cycle where it stands.
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// A hang is cut short and counted as a mismatch.
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("BAD watchdog expected finish seen hang");
		end_of_test();
	end

	// Main sequence: configure, row table, then the awkward cases.
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		wr_reg(A_PORT_LO, 32'h8);
		wr_reg(A_PORT_HI, 32'h100);
		wr_reg(A_VLAN_IDX, 32'h5);
		wr_reg(A_VLAN_DAT, 32'h1);
		wr_reg(A_VLAN_IDX, 32'h7);
		wr_reg(A_VLAN_DAT, 32'h3);
		wr_reg(A_VLAN_IDX, 32'h9);
		wr_reg(A_VLAN_DAT, 32'h2);
		wr_reg(8'h30, 32'hffffffff);
		rd_reg(A_VLAN_DAT, 32'h2);
		rd_reg(A_PORT_HI, 32'h100);
		rd_reg(8'h30, 32'h0);
		fin("registers");
		for (int i = 0; i < 8; i++) begin
			i_pkt_parser_model.send(rows[i].p[5:0], rows[i].t[0], rows[i].v[11:0], rows[i].l[7:0]);
			#1 chk("to_flow", rows[i].f, to_f);
			chk("to_normal", rows[i].f == 0, to_n);
			chk("ttl_class", rows[i].c, ttlc);
			chk("src_mask", 64'h1 << rows[i].p, smk);
		end
		fin("steering");
		// Key words for every destination MAC class and both trunk states.
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			fx <= {FXB[117:3], i[0], i[1:0]};
			ast <= 4'h3;
			asd <= 12'h5a5;
			i_pkt_parser_model.send(6'd5, 1'b1, 12'habc, 8'd9);
			cls = fx[0] ? MAC_BC : (fx[1] ? MAC_MC : MAC_UC);
			#1 chk("class_word", {6'd5, cls, 8'h0}, w_cls);
			chk("slp_word", fx[2] ? {5'h0, 1'b1, 3'h0, fx[9:3]}
				: {5'h0, 1'b0, fx[13:10], 6'd5}, w_slp);
			chk("dlp_word", {4'h3, 12'h5a5}, w_dlp);
			chk("meta_word", {fx[48:45], fx[60:49]}, w_md);
			chk("outer_tag", {3'h5, 1'b1, 12'habc}, w_ot);
			chk("inner_tag", {3'h2, 1'b0, ~12'habc}, w_it);
			chk("tunnel_word", {fx[15:14], 14'h0}, w_tt);
			chk("transport_word", {3'h0, fx[28:16]}, w_tr);
			chk("range_in", fx[44:29], rm);
			chk("range_eg", fx[44:29] & ~RNG_LEN_BITS, rme);
			chk("dst_mask", {7'h0, fx[117:61]}, dmk);
		end
		fin("key_words");
		// Every loopback origin and target, one after another.
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			lbv <= 1'b1;
			lbf <= i[1];
			lbt <= i[0];
			@(posedge clk);
			lbv <= 1'b0;
			#1 chk("lb_to_flow", i == 3, to_f);
			chk("lb_flag", 1, smk[63]);
		end
		fin("loopback");
		// Every action set output type.
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			asv <= 1'b1;
			ast <= i[3:0];
			@(posedge clk);
			asv <= 1'b0;
			#1 chk("egress_go", i != 0 && i != 8, eg);
			chk("lb_normal", i == 8, lbn);
		end
		fin("action_set");
		// Entry 2 inverts, entry 3 chains within its block, entry 4 across blocks.
		wr_reg(A_ENT_SEL, 32'h2);
		wr_reg(A_ENT_OPS, 32'h1);
		wr_reg(A_ENT_SEL, 32'h3);
		wr_reg(A_ENT_OPS, 32'h2);
		wr_reg(A_ENT_SEL, 32'h4);
		wr_reg(A_ENT_OPS, 32'h4);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			mv <= 1'b1;
			raw <= mt[i][15:8];
			mlen <= 14'd100;
			@(posedge clk);
			mv <= 1'b0;
			#1 chk("entry_match", mt[i][7:0], em);
		end
		wr_reg(A_ENT_SEL, 32'h1);
		rd_reg(A_HIT, 32'h7);
		rd_reg(A_PKT_LO, 32'h1);
		rd_reg(A_PKT_HI, 32'h0);
		rd_reg(A_BYTE_LO, 32'h64);
		rd_reg(A_BYTE_HI, 32'h0);
		wr_reg(A_HIT, 32'h2);
		rd_reg(A_HIT, 32'h5);
		fin("entries");
		// A frozen core must ignore a packet that would steer to flow.
		@(posedge clk);
		ce <= 1'b0;
		i_pkt_parser_model.send(6'd3, 1'b0, 12'h5, 8'd1);
		#1 chk("ce_hold", 0, to_f);
		@(posedge clk);
		ce <= 1'b1;
		fin("clock_enable");
		// Reset in mid-run clears outputs and every table.
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("to_flow_rst", 0, to_f);
		chk("src_mask_rst", 0, smk);
		@(posedge clk);
		nrst <= 1'b1;
		rd_reg(A_PORT_LO, PORT_EN_RST[31:0]);
		rd_reg(A_VLAN_DAT, {30'h0, VLAN_RST});
		rd_reg(A_ENT_OPS, {29'h0, OPS_RST});
		rd_reg(A_HIT, 32'h0);
		fin("reset");
		end_of_test();
	end
endmodule
